// File: design/tmr_replace_ptr.sv
`default_nettype none
module tmr_replace_ptr
  import tmr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       step,
  input  wire logic       reload,
  input  wire logic [4:0] bound,
  output logic [5:0]      ptr
);
  // =========================================
  // victim pointer, stepped once per retired instruction
  always_ff @(posedge clk) begin
    if (rst || reload) begin
      ptr <= RND_UPPER;
    end else if (step) begin
      // at or below the bound it wraps, so a raised bound is obeyed at once
      if (ptr[4:0] <= bound) begin
        ptr <= RND_UPPER;
      end else begin
        ptr <= ptr - 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: design/tmr_tlb_entry.sv
`default_nettype none
module tmr_tlb_entry
  import tmr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        wr_en,
  input  wire tmr_entry_s  wr_data,
  input  wire logic        mode64,
  input  wire logic [63:0] vaddr,
  input  wire logic [7:0]  address_space_id,
  output tmr_entry_s       q,
  output logic             hit
);
  // =========================================
  // storage: contents undefined until software writes them
  always_ff @(posedge clk) begin
    if (wr_en) begin
      q <= wr_data;
    end
  end
  // =========================================
  // match
  logic [26:0] va_vpn;
  logic [26:0] cmp_mask;
  logic        vpn_ok;
  logic        reg_ok;
  always_comb begin
    va_vpn   = vaddr[TAG_VPN64_MSB:TAG_VPN_LSB];
    cmp_mask = mode64 ? {15'h7fff, ~q.tag.mask} : {8'h00, 7'h7f, ~q.tag.mask};
    vpn_ok   = ((va_vpn ^ q.tag.page_pair_number) & cmp_mask) == 27'h000_0000;
    reg_ok   = !mode64 || (vaddr[63:TAG_REG_LSB] == q.tag.region);
    // global only when both halves were global at write time
    hit = vpn_ok && reg_ok &&
          (q.even.global || q.tag.address_space_id == address_space_id);
  end
endmodule
`default_nettype wire

// File: design/tmr_tlb_regs.sv
`default_nettype none
module tmr_tlb_regs
  import tmr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        mode64,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [4:0]  reg_num,
  input  wire logic [63:0] reg_wdata,
  output logic [63:0]      reg_rdata,
  input  wire logic        probe_instruction,
  input  wire logic        indexed_read_instruction,
  input  wire logic        indexed_write_instruction,
  input  wire logic        random_write_instruction,
  input  wire logic        instr_retire,
  input  wire logic        lk_valid,
  input  wire logic        lk_store,
  input  wire logic [63:0] lk_vaddr,
  output logic             lk_done,
  output logic             lk_hit,
  output logic             lk_refill,
  output logic             lk_invalid,
  output logic             lk_modify,
  output logic             lk_cached,
  output logic [2:0]       lk_attr,
  output logic [19:0]      lk_frame_number
);
  // =========================================
  // staging state
  tmr_tag_s   tlb_tag_staging;
  tmr_frame_s even_page_frame;
  tmr_frame_s odd_page_frame;
  logic [5:0] index_sel;
  logic       index_p;
  logic [5:0] wired_bound;
  logic [5:0] rnd_ptr;

  // =========================================
  // entry array
  tmr_entry_s            ent_q [ENTRIES];
  logic [ENTRIES-1:0]    ent_hit;
  logic [ENTRIES-1:0]    ent_wr;
  tmr_entry_s            wr_entry;
  logic [4:0]            wr_idx;
  logic                  tlb_write;

  assign tlb_write = indexed_write_instruction || random_write_instruction;
  // only the low five bits ever reach the array
  assign wr_idx = random_write_instruction ? rnd_ptr[4:0] : index_sel[4:0];
  // a probe borrows the lookup comparators with the staged tag as address;
  // a lookup in the same cycle as a probe is not supported
  logic [63:0] cmp_vaddr;
  assign cmp_vaddr = probe_instruction ? {tlb_tag_staging.region, 22'h00_0000,
                     tlb_tag_staging.page_pair_number, 13'h0000} : lk_vaddr;

  always_comb begin
    wr_entry.tag         = tlb_tag_staging;
    wr_entry.even        = even_page_frame;
    wr_entry.odd         = odd_page_frame;
    wr_entry.even.global = even_page_frame.global && odd_page_frame.global;
    wr_entry.odd.global  = even_page_frame.global && odd_page_frame.global;
  end

  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++) begin : g_ent
      assign ent_wr[gi] = tlb_write && (wr_idx == 5'(gi));
      tmr_tlb_entry u_ent (
        .clk              (clk),
        .wr_en            (ent_wr[gi]),
        .wr_data          (wr_entry),
        .mode64           (mode64),
        .vaddr            (cmp_vaddr),
        .address_space_id (tlb_tag_staging.address_space_id),
        .q                (ent_q[gi]),
        .hit              (ent_hit[gi])
      );
    end
  endgenerate

  // =========================================
  // hit encode; multiple hits are a software error, lowest wins
  logic       any_hit;
  logic [4:0] hit_idx;
  tmr_entry_s hit_ent;
  tmr_frame_s hit_frame;
  logic [12:0] sel_ext;
  logic [12:0] sel_top;
  logic        odd_page;
  always_comb begin
    any_hit = |ent_hit;
    hit_idx = 5'h00;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (ent_hit[i]) begin
        hit_idx = 5'(i);
      end
    end
    hit_ent   = ent_q[hit_idx];
    // even/odd select bit sits just above the masked page offset
    sel_ext   = {hit_ent.tag.mask, 1'b1};
    sel_top   = sel_ext & ~{1'b0, sel_ext[12:1]};
    odd_page  = |(lk_vaddr[24:12] & sel_top);
    hit_frame = odd_page ? hit_ent.odd : hit_ent.even;
  end

  // =========================================
  // lookup result, one cycle after the request
  logic fault;
  assign fault = lk_valid && (!any_hit || !hit_frame.valid ||
                 (lk_store && !hit_frame.dirty));
  always_ff @(posedge clk) begin
    if (rst) begin
      lk_done    <= 1'b0;
      lk_hit     <= 1'b0;
      lk_refill  <= 1'b0;
      lk_invalid <= 1'b0;
      lk_modify  <= 1'b0;
      lk_cached  <= 1'b0;
      lk_attr    <= 3'h0;
      lk_frame_number <= 20'h0_0000;
    end else begin
      lk_done    <= lk_valid;
      lk_hit     <= lk_valid && !fault;
      lk_refill  <= lk_valid && !any_hit;
      lk_invalid <= lk_valid && any_hit && !hit_frame.valid;
      lk_modify  <= lk_valid && any_hit && hit_frame.valid &&
                    lk_store && !hit_frame.dirty;
      lk_attr    <= hit_frame.attr;
      lk_cached  <= hit_frame.attr != ATTR_UNCACHED;
      lk_frame_number <= hit_frame.frame_number;
    end
  end

  // =========================================
  // tag staging: software, indexed read, fault capture
  tmr_entry_s rd_ent;
  assign rd_ent = ent_q[index_sel[4:0]];
  always_ff @(posedge clk) begin
    if (fault) begin
      // the identifier already held is the current one, so it stays
      tlb_tag_staging.page_pair_number <= mode64 ? lk_vaddr[TAG_VPN64_MSB:TAG_VPN_LSB]
          : {8'h00, lk_vaddr[TAG_VPN32_MSB:TAG_VPN_LSB]};
      tlb_tag_staging.region <= mode64 ? lk_vaddr[63:TAG_REG_LSB] : REGION_USER;
    end else if (indexed_read_instruction) begin
      tlb_tag_staging <= rd_ent.tag;
    end else if (reg_wr && reg_num == REG_TAG) begin
      tlb_tag_staging.address_space_id <= reg_wdata[7:0];
      // filler 61:40 and bits 12:8 are dropped on write
      tlb_tag_staging.page_pair_number <= mode64 ? reg_wdata[TAG_VPN64_MSB:TAG_VPN_LSB]
          : {8'h00, reg_wdata[TAG_VPN32_MSB:TAG_VPN_LSB]};
      tlb_tag_staging.region <= mode64 ? reg_wdata[63:TAG_REG_LSB] : REGION_USER;
    end
    // mask has its own path, so a fault capture cannot swallow a mask write
    if (indexed_read_instruction) begin
      tlb_tag_staging.mask <= rd_ent.tag.mask;
    end else if (reg_wr && reg_num == REG_MASK) begin
      tlb_tag_staging.mask <= reg_wdata[MASK_MSB:MASK_LSB];
    end
  end

  // =========================================
  // page frames
  always_ff @(posedge clk) begin
    if (indexed_read_instruction) begin
      even_page_frame <= rd_ent.even;
      odd_page_frame  <= rd_ent.odd;
    end else if (reg_wr && reg_num == REG_EVEN) begin
      even_page_frame <= reg_wdata[FRM_FRAME_MSB:0];
    end else if (reg_wr && reg_num == REG_ODD) begin
      odd_page_frame  <= reg_wdata[FRM_FRAME_MSB:0];
    end
  end

  // =========================================
  // index register and probe
  always_ff @(posedge clk) begin
    if (probe_instruction) begin
      index_p <= !any_hit;
      if (any_hit) begin
        index_sel <= {1'b0, hit_idx};
      end
    end else if (reg_wr && reg_num == REG_INDEX) begin
      index_p   <= reg_wdata[IDX_PROBE];
      index_sel <= reg_wdata[IDX_W-1:0];
    end
  end

  // =========================================
  // wired bound and replacement pointer
  logic wired_wr;
  assign wired_wr = reg_wr && reg_num == REG_WIRED;
  always_ff @(posedge clk) begin
    if (rst) begin
      wired_bound <= WIRED_RESET;
    end else if (wired_wr) begin
      wired_bound <= reg_wdata[5:0];
    end
  end

  tmr_replace_ptr u_rnd (
    .clk    (clk),
    .rst    (rst),
    .step   (instr_retire),
    .reload (wired_wr),
    .bound  (wired_bound[4:0]),
    .ptr    (rnd_ptr)
  );

  // =========================================
  // register read port; unused numbers read zero
  logic [63:0] next_rdata;
  always_comb begin
    next_rdata = 64'h0000_0000_0000_0000;
    case (reg_num)
      REG_INDEX:  next_rdata = {32'h0000_0000, index_p, 25'h000_0000, index_sel};
      REG_RANDOM: next_rdata = {58'h0, rnd_ptr};
      REG_EVEN:   next_rdata = {38'h0, even_page_frame};
      REG_ODD:    next_rdata = {38'h0, odd_page_frame};
      REG_MASK:   next_rdata = {39'h0, tlb_tag_staging.mask, 13'h0000};
      REG_WIRED:  next_rdata = {58'h0, wired_bound};
      REG_TAG: begin
        // no global bit here: the frames carry it
        if (mode64) begin
          next_rdata = {tlb_tag_staging.region, 22'h00_0000, tlb_tag_staging.page_pair_number,
                        5'h00, tlb_tag_staging.address_space_id};
        end else begin
          next_rdata = {32'h0000_0000, tlb_tag_staging.page_pair_number[18:0], 5'h00,
                        tlb_tag_staging.address_space_id};
        end
      end
      default: next_rdata = 64'h0000_0000_0000_0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 64'h0000_0000_0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // =========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_probe_miss;
    probe_instruction && !any_hit;
  endsequence
  sequence s_probe_hit;
    probe_instruction && any_hit;
  endsequence
  sequence s_fault32;
    fault && !mode64;
  endsequence
  sequence s_lookup_miss;
    lk_valid && !any_hit;
  endsequence

  mask_read_zero_a: assert property (
    reg_rd && reg_num == REG_MASK |=> reg_rdata[63:25] == 39'h0 && reg_rdata[12:0] == 13'h0)
    else $error("mask register reserved bits not zero");
  tag_fill_zero_a: assert property (
    reg_rd && reg_num == REG_TAG && mode64 |=> reg_rdata[61:40] == 22'h0 &&
    reg_rdata[12:8] == 5'h0)
    else $error("tag filler bits not zero");
  probe_miss_flag_a: assert property (
    s_probe_miss |=> index_p)
    else $error("probe miss did not set flag");
  probe_hit_flag_a: assert property (
    s_probe_hit |=> !index_p && index_sel == {1'b0, $past(hit_idx)})
    else $error("probe hit did not load index");
  random_bounds_a: assert property (
    rnd_ptr[4:0] >= wired_bound[4:0] || rnd_ptr == RND_UPPER)
    else $error("replacement pointer out of range");
  wired_reload_a: assert property (
    wired_wr |=> rnd_ptr == RND_UPPER)
    else $error("pointer not reloaded after wired write");
  invalid_miss_a: assert property (
    lk_valid && any_hit && !hit_frame.valid |=> lk_invalid && !lk_hit)
    else $error("invalid page did not raise miss");
  store_protect_a: assert property (
    lk_valid && lk_store && any_hit && hit_frame.valid && !hit_frame.dirty
    |=> lk_modify && !lk_hit)
    else $error("store to clean page not blocked");
  uncached_attr_a: assert property (
    lk_done |-> lk_cached == (lk_attr != ATTR_UNCACHED))
    else $error("cache attribute decode wrong");
  capture_tag_a: assert property (
    s_fault32 |=> tlb_tag_staging.page_pair_number[18:0] == $past(lk_vaddr[31:13]))
    else $error("fault address not captured");
  probe_miss_keep_a: assert property (
    s_probe_miss |=> index_sel == $past(index_sel))
    else $error("probe miss changed index field");
  tag32_zero_a: assert property (
    reg_rd && reg_num == REG_TAG && !mode64 |=> reg_rdata[63:32] == 32'h0000_0000 &&
    reg_rdata[12:8] == 5'h00)
    else $error("32-bit tag reserved bits not zero");
  frame_zero_a: assert property (
    reg_rd && (reg_num == REG_EVEN || reg_num == REG_ODD) |=> reg_rdata[63:26] == 38'h0)
    else $error("frame upper bits not zero");
  index_zero_a: assert property (
    reg_rd && reg_num == REG_INDEX |=> reg_rdata[63:32] == 32'h0000_0000 &&
    reg_rdata[30:6] == 25'h000_0000)
    else $error("index reserved bits not zero");
  random_view_a: assert property (
    reg_rd && reg_num == REG_RANDOM |=> reg_rdata == {58'h0, $past(rnd_ptr)})
    else $error("replacement pointer read wrong");
  refill_flag_a: assert property (
    s_lookup_miss |=> lk_refill && !lk_hit)
    else $error("lookup miss not flagged");
  random_target_a: assert property (
    random_write_instruction |-> ent_wr == (32'h0000_0001 << rnd_ptr[4:0]))
    else $error("random write hit wrong entry");
  indexed_target_a: assert property (
    indexed_write_instruction && !random_write_instruction |->
    ent_wr == (32'h0000_0001 << index_sel[4:0]))
    else $error("indexed write hit wrong entry");
endmodule
`default_nettype wire

// File: shared/tmr_pkg.sv
`default_nettype none
package tmr_pkg;
  // =========================================
  // register numbers
  localparam logic [4:0] REG_INDEX    = 5'h00;
  localparam logic [4:0] REG_RANDOM   = 5'h01;
  localparam logic [4:0] REG_EVEN     = 5'h02;
  localparam logic [4:0] REG_ODD      = 5'h03;
  localparam logic [4:0] REG_MASK     = 5'h05;
  localparam logic [4:0] REG_WIRED    = 5'h06;
  localparam logic [4:0] REG_TAG      = 5'h0a;
  // =========================================
  // field positions
  localparam int MASK_LSB    = 13;
  localparam int MASK_MSB    = 24;
  localparam int TAG_VPN_LSB = 13;
  localparam int TAG_VPN32_MSB = 31;
  localparam int TAG_VPN64_MSB = 39;
  localparam int TAG_REG_LSB = 62;
  localparam int FRM_FRAME_LSB = 6;
  localparam int FRM_FRAME_MSB = 25;
  localparam int IDX_PROBE   = 31;
  localparam int IDX_W       = 6;
  // =========================================
  // reset values and encodings
  localparam logic [5:0] RND_UPPER   = 6'h1f;
  localparam logic [5:0] WIRED_RESET = 6'h00;
  localparam logic [2:0] ATTR_UNCACHED = 3'h2;
  localparam logic [1:0] REGION_USER   = 2'h0;
  localparam logic [1:0] REGION_SUPER  = 2'h1;
  localparam logic [1:0] REGION_KERNEL = 2'h3;
  localparam int ENTRIES = 32;
  // =========================================
  // carriers
  typedef struct packed {
    logic [11:0] mask;
    logic [1:0]  region;
    logic [26:0] page_pair_number;
    logic [7:0]  address_space_id;
  } tmr_tag_s;
  typedef struct packed {
    logic [19:0] frame_number;
    logic [2:0]  attr;
    logic        dirty;
    logic        valid;
    logic        global;
  } tmr_frame_s;
  typedef struct packed {
    tmr_tag_s   tag;
    tmr_frame_s even;
    tmr_frame_s odd;
  } tmr_entry_s;
endpackage
`default_nettype wire

// File: testbench/tb_top.sv
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module tb_top
  import tmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] OP_PROBE = 5'h10;
  localparam logic [4:0] OP_READ  = 5'h08;
  localparam logic [4:0] OP_WRITE = 5'h04;
  localparam logic [4:0] OP_RAND  = 5'h02;
  localparam logic [4:0] OP_RET   = 5'h01;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  wire logic   mode64, reg_wr, reg_rd, lk_valid, lk_store;
  wire logic [4:0]  reg_num, ops;
  wire logic [63:0] reg_wdata, reg_rdata, lk_vaddr;
  wire logic [28:0] lk_res;
  int          errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [63:0] d;
  logic [28:0] r;
  // =========================================
  // clock, watchdog, instances
  always #5 clk = ~clk;
  tmr_tlb_regs dut_u (.clk(clk), .rst(rst), .mode64(mode64), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_num(reg_num), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .probe_instruction(ops[4]), .indexed_read_instruction(ops[3]),
    .indexed_write_instruction(ops[2]), .random_write_instruction(ops[1]),
    .instr_retire(ops[0]), .lk_valid(lk_valid), .lk_store(lk_store), .lk_vaddr(lk_vaddr),
    .lk_done(lk_res[28]), .lk_hit(lk_res[27]), .lk_refill(lk_res[26]),
    .lk_invalid(lk_res[25]), .lk_modify(lk_res[24]), .lk_cached(lk_res[23]),
    .lk_attr(lk_res[22:20]), .lk_frame_number(lk_res[19:0]));
  tmr_pipe_model pipe_u (.clk(clk), .reg_rdata(reg_rdata), .lk_res(lk_res),
    .mode64(mode64), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_num(reg_num),
    .reg_wdata(reg_wdata), .ops(ops), .lk_valid(lk_valid), .lk_store(lk_store),
    .lk_vaddr(lk_vaddr));
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  // =========================================
  // helpers
  function automatic logic [63:0] tag32(logic [18:0] v, logic [7:0] a);
    return {32'h0, v, 5'h0, a};
  endfunction
  function automatic logic [63:0] frm(logic [19:0] p, logic [2:0] c, logic [2:0] dvg);
    return {38'h0, p, c, dvg};
  endfunction
  function automatic logic [63:0] va(logic [18:0] v, logic odd);
    return {32'h0, v, odd, 12'h0};
  endfunction
  task automatic set_entry(input logic [5:0] i, input logic [63:0] t, e, o);
    pipe_u.wr(REG_TAG, t);
    pipe_u.wr(REG_EVEN, e);
    pipe_u.wr(REG_ODD, o);
    pipe_u.wr(REG_INDEX, {58'h0, i});
    pipe_u.op(OP_WRITE);
  endtask
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // =========================================
  // scenarios
  task automatic t_reset();
    pipe_u.rd(REG_RANDOM, d);
    `CHK(d, 64'h1f)
    pipe_u.rd(REG_WIRED, d);
    `CHK(d, 64'h0)
    pipe_u.wr(REG_RANDOM, 64'h5);
    pipe_u.rd(REG_RANDOM, d);
    `CHK(d, 64'h1f)
    pipe_u.rd(5'h04, d);
    `CHK(d, 64'h0)
  endtask
  task automatic t_layout();
    logic [1:0] rg [3] = '{REGION_USER, REGION_SUPER, REGION_KERNEL};
    pipe_u.wr(REG_MASK, '1);
    pipe_u.rd(REG_MASK, d);
    `CHK(d, 64'h01ff_e000)
    pipe_u.wr(REG_EVEN, '1);
    pipe_u.rd(REG_EVEN, d);
    `CHK(d, 64'h03ff_ffff)
    pipe_u.wr(REG_TAG, '1);
    pipe_u.rd(REG_TAG, d);
    `CHK(d, 64'hffff_e0ff)
    pipe_u.wr(REG_INDEX, '1);
    pipe_u.rd(REG_INDEX, d);
    `CHK(d[30:0], 31'h3f)
    pipe_u.set_mode(1'b1);
    foreach (rg[k]) begin
      pipe_u.wr(REG_TAG, {rg[k], 62'h3fff_ffff_ffff_ffff});
      pipe_u.rd(REG_TAG, d);
      `CHK(d, {rg[k], 22'h0, 27'h7ff_ffff, 13'h00ff})
    end
    pipe_u.set_mode(1'b0);
    pipe_u.wr(REG_MASK, 64'h0);
  endtask
  // bit 5 of the index is stored but must not pick a different entry
  task automatic t_entry();
    set_entry(6'h21, tag32(19'h1234, 8'h5a), frm(20'habcde, 3'h3, 3'b110),
      frm(20'h12345, 3'h5, 3'b010));
    pipe_u.rd(REG_INDEX, d);
    `CHK(d, 64'h21)
    pipe_u.wr(REG_TAG, 64'h0);
    pipe_u.wr(REG_EVEN, 64'h0);
    pipe_u.wr(REG_ODD, 64'h0);
    pipe_u.wr(REG_INDEX, 64'h1);
    pipe_u.op(OP_READ);
    pipe_u.rd(REG_TAG, d);
    `CHK(d, tag32(19'h1234, 8'h5a))
    pipe_u.rd(REG_EVEN, d);
    `CHK(d, frm(20'habcde, 3'h3, 3'b110))
    pipe_u.rd(REG_ODD, d);
    `CHK(d, frm(20'h12345, 3'h5, 3'b010))
  endtask
  task automatic t_probe();
    pipe_u.wr(REG_INDEX, 64'h7);
    pipe_u.op(OP_PROBE);
    pipe_u.rd(REG_INDEX, d);
    `CHK(d, 64'h1)
    pipe_u.wr(REG_TAG, tag32(19'h1234, 8'h5b));
    pipe_u.op(OP_PROBE);
    pipe_u.rd(REG_INDEX, d);
    `CHK(d, 64'h8000_0001)
  endtask
  task automatic t_lookup();
    pipe_u.wr(REG_TAG, tag32(19'h1234, 8'h5a));
    pipe_u.look(1'b0, va(19'h1234, 1'b0), r);
    `CHK(r, {5'b11000, 1'b1, 3'h3, 20'habcde})
    pipe_u.look(1'b0, va(19'h1234, 1'b1), r);
    `CHK(r, {5'b11000, 1'b1, 3'h5, 20'h12345})
    pipe_u.look(1'b1, va(19'h1234, 1'b1), r);
    `CHK(r[28:24], 5'b10001)
    pipe_u.look(1'b1, va(19'h1234, 1'b0), r);
    `CHK(r[28:24], 5'b11000)
    set_entry(6'h02, tag32(19'h2000, 8'h77), frm(20'h11111, 3'h0, 3'b001),
      frm(20'h22222, 3'h0, 3'b011));
    set_entry(6'h03, tag32(19'h3000, 8'h77), frm(20'h0, 3'h0, 3'b011), frm(20'h0, 3'h0, 3'b010));
    pipe_u.wr(REG_TAG, tag32(19'h0333, 8'h5a));
    pipe_u.look(1'b0, va(19'h2000, 1'b0), r);
    `CHK(r[28:24], 5'b10010)
    pipe_u.look(1'b0, va(19'h2000, 1'b1), r);
    `CHK(r, {5'b11000, 1'b1, 3'h0, 20'h22222})
    pipe_u.look(1'b0, va(19'h3000, 1'b0), r);
    `CHK(r[28:24], 5'b10100)
    pipe_u.rd(REG_TAG, d);
    `CHK(d, tag32(19'h3000, 8'h5a))
    for (int c = 0; c < 8; c++) begin
      set_entry(6'h04, tag32(19'h4000, 8'h5a), frm(20'h0, 3'(c), 3'b110), 64'h0);
      pipe_u.look(1'b0, va(19'h4000, 1'b0), r);
      `CHK(r[28:20], {5'b11000, c != 2, 3'(c)})
    end
  endtask
  task automatic t_random();
    pipe_u.wr(REG_WIRED, 64'h1e);
    pipe_u.rd(REG_WIRED, d);
    `CHK(d, 64'h1e)
    pipe_u.rd(REG_RANDOM, d);
    `CHK(d, 64'h1f)
    for (int k = 0; k < 3; k++) begin
      pipe_u.op(OP_RET);
      pipe_u.rd(REG_RANDOM, d);
      `CHK(d, (k == 1) ? 64'h1f : 64'h1e)
    end
    pipe_u.wr(REG_TAG, tag32(19'h5555, 8'h5a));
    pipe_u.op(OP_RAND);
    pipe_u.wr(REG_TAG, 64'h0);
    pipe_u.wr(REG_INDEX, 64'h1e);
    pipe_u.op(OP_READ);
    pipe_u.rd(REG_TAG, d);
    `CHK(d, tag32(19'h5555, 8'h5a))
  endtask
  // =========================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    pipe_u.init_regs();
    t_layout();
    t_entry();
    t_probe();
    t_lookup();
    t_random();
    stop_test();
  end
endmodule
`default_nettype wire

// File: testbench/tmr_pipe_model.sv
`default_nettype none
// =========================================
// pipeline side: register moves, tlb instructions, lookups
module tmr_pipe_model
  import tmr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [63:0] reg_rdata,
  input  wire logic [28:0] lk_res,
  output logic             mode64,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [4:0]       reg_num,
  output logic [63:0]      reg_wdata,
  output logic [4:0]       ops,
  output logic             lk_valid,
  output logic             lk_store,
  output logic [63:0]      lk_vaddr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {mode64, reg_wr, reg_rd, reg_num, reg_wdata, ops} = '0;
    {lk_valid, lk_store, lk_vaddr} = '0;
  end
  task automatic set_mode(input logic m);
    @(posedge clk);
    mode64 <= m;
  endtask
  // released bus shows the inverse so stale data cannot pass
  task automatic wr(input logic [4:0] num, input logic [63:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_num   <= num;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [4:0] num, output logic [63:0] d);
    @(posedge clk);
    reg_rd  <= 1'b1;
    reg_num <= num;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic op(input logic [4:0] o);
    @(posedge clk);
    ops <= o;
    @(posedge clk);
    ops <= '0;
  endtask
  task automatic look(input logic st, input logic [63:0] va, output logic [28:0] r);
    @(posedge clk);
    lk_valid <= 1'b1;
    lk_store <= st;
    lk_vaddr <= va;
    @(posedge clk);
    lk_valid <= 1'b0;
    lk_vaddr <= ~va;
    #1 r = lk_res;
  endtask
  // staging and every entry start defined; filler tag kept out of use
  task automatic init_regs();
    wr(REG_MASK, 64'h0);
    wr(REG_EVEN, 64'h0);
    wr(REG_ODD, 64'h0);
    wr(REG_TAG, 64'hffff_e0ff);
    for (int i = 0; i < ENTRIES; i++) begin
      wr(REG_INDEX, 64'(i));
      op(5'h04);
    end
  endtask
endmodule
`default_nettype wire
